// *** design/scf_defs.svh ***
/*
 Offsets, field positions, reset values and masks of the
 processor flags block. Assumes APB with 32-bit data.
*/
`ifndef SCF_DEFS_SVH
`define SCF_DEFS_SVH
`define SCF_FLAGS_OFS   8'h00
`define SCF_SET_OFS     8'h04
`define SCF_CLR_OFS     8'h08
`define SCF_ISTAT_OFS   8'h0C
`define SCF_IMASK_OFS   8'h10
`define SCF_LVD_BIT     7
`define SCF_SPARE_BIT   6
`define SCF_BANK_BIT    5
`define SCF_WDT_BIT     4
`define SCF_PD_BIT      3
`define SCF_ZERO_BIT    2
`define SCF_NIB_BIT     1
`define SCF_MSB_BIT     0
`define SCF_FLAGS_RST   8'h00
`define SCF_SW_MASK     8'h67
`define SCF_EV_WDT      0
`define SCF_EV_SLEEP    1
`define SCF_EV_LVD      2
`define SCF_EV_RST      3'h0
`endif

// *** design/scf_pkg.sv ***
/*
 Types of the processor flags block.
 Assumes scf_defs.svh for numbers.
*/
package scf_pkg;
	// ALU flag result, one per flag-affecting op
	typedef struct packed {
		logic upd;
		logic zero;
		logic nib_carry;
		logic msb_carry;
	} scf_alu_s;
	typedef logic [2:0] scf_idx_t;
endpackage

// *** design/scf_status_flags.sv ***
/*
 Processor flags register with APB access, bit set and
 clear windows, and a small event interrupt. Assumes the
 core drives its event strobes on core_clk; the supply
 detector output is asynchronous.
*/
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "scf_defs.svh"
module scf_status_flags (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// Core events
	input  wire scf_pkg::scf_alu_s alu_result,
	input  wire logic             sleep_exec,
	input  wire logic             watchdog_kick_instruction,
	input  wire logic             watchdog_timeout,
	input  wire logic             low_voltage_reset,
	// Supply detector
	input  wire logic             supply_below_pin,
	input  wire logic             low_voltage_reset_enable,
	input  wire logic             supply_filter_select,
	// Outputs to core
	output logic      [7:0]       processor_flags,
	output logic                  memory_bank_select,
	output logic                  irq
);
	import scf_pkg::*;

	////////////////////////////////////////////////////////
	// Address decode
	function automatic scf_idx_t reg_index(
		input logic [7:0] a);
		scf_idx_t r;
		r = 3'h7;
		case (a)
			`SCF_FLAGS_OFS: r = 3'h0;
			`SCF_SET_OFS:   r = 3'h1;
			`SCF_CLR_OFS:   r = 3'h2;
			`SCF_ISTAT_OFS: r = 3'h3;
			`SCF_IMASK_OFS: r = 3'h4;
			default:        r = 3'h7;
		endcase
		return r;
	endfunction

	logic       setup_ph;
	logic       wr_fire;
	scf_idx_t   wr_idx;
	scf_idx_t   rd_idx;
	logic [7:0] sw_data;
	logic [2:0] ist;
	logic [2:0] imask;
	logic [2:0] next_ist;
	logic [2:0] events;
	logic [7:0] next_flags;
	logic       lvd_s1;
	logic       lvd_s2;
	logic       next_lvd;

	assign setup_ph = psel & ~penable;
	assign wr_fire  = psel & penable & pready & pwrite;
	assign wr_idx   = reg_index(paddr);
	assign rd_idx   = reg_index(paddr);
	assign sw_data  = pwdata[7:0] & `SCF_SW_MASK;

	////////////////////////////////////////////////////////
	// APB answer, one cycle after setup
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & (rd_idx == 3'h7);
		end
	end

	// Read data captured in setup phase
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph & ~pwrite) begin
			case (rd_idx)
				3'h0:    prdata <= {24'h00_0000, processor_flags};
				3'h3:    prdata <= {29'h0, ist};
				3'h4:    prdata <= {29'h0, imask};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////
	// Supply detector synchroniser
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			lvd_s1 <= 1'b0;
			lvd_s2 <= 1'b0;
		end else begin
			lvd_s1 <= supply_below_pin;
			lvd_s2 <= lvd_s1;
		end
	end

	// Low-voltage flag gating
	assign next_lvd = lvd_s2 & low_voltage_reset_enable
		& ~supply_filter_select;

	////////////////////////////////////////////////////////
	// Next flag value
	always_comb begin
		next_flags = processor_flags;
		// Whole write keeps hardware-only bits
		if (wr_fire && wr_idx == 3'h0) begin
			next_flags = (processor_flags & ~`SCF_SW_MASK)
				| sw_data;
		end
		// Bit set window
		if (wr_fire && wr_idx == 3'h1) begin
			next_flags = next_flags | sw_data;
		end
		// Bit clear window
		if (wr_fire && wr_idx == 3'h2) begin
			next_flags = next_flags & ~sw_data;
		end
		// ALU result overrides software
		if (alu_result.upd) begin
			next_flags[`SCF_ZERO_BIT] = alu_result.zero;
			next_flags[`SCF_NIB_BIT]  = alu_result.nib_carry;
			next_flags[`SCF_MSB_BIT]  = alu_result.msb_carry;
		end
		// Watchdog expired, set wins
		if (watchdog_kick_instruction | sleep_exec
			| low_voltage_reset) begin
			next_flags[`SCF_WDT_BIT] = 1'b0;
		end
		if (watchdog_timeout) begin
			next_flags[`SCF_WDT_BIT] = 1'b1;
		end
		// Power down, set wins
		if (watchdog_kick_instruction | low_voltage_reset) begin
			next_flags[`SCF_PD_BIT] = 1'b0;
		end
		if (sleep_exec) begin
			next_flags[`SCF_PD_BIT] = 1'b1;
		end
		next_flags[`SCF_LVD_BIT] = next_lvd;
	end

	// Flags register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			processor_flags <= `SCF_FLAGS_RST;
		end else begin
			processor_flags <= next_flags;
		end
	end

	// Bank select to memory decode
	assign memory_bank_select = processor_flags[`SCF_BANK_BIT];

	////////////////////////////////////////////////////////
	// Interrupt events
	always_comb begin
		events = 3'h0;
		events[`SCF_EV_WDT]   = watchdog_timeout;
		events[`SCF_EV_SLEEP] = sleep_exec;
		events[`SCF_EV_LVD]   = next_lvd
			& ~processor_flags[`SCF_LVD_BIT];
	end

	// Sticky status, write one clears, set wins
	always_comb begin
		next_ist = ist;
		if (wr_fire && wr_idx == 3'h3) begin
			next_ist = ist & ~pwdata[2:0];
		end
		next_ist = next_ist | events;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ist <= `SCF_EV_RST;
		end else begin
			ist <= next_ist;
		end
	end

	// Interrupt mask
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			imask <= `SCF_EV_RST;
		end else if (wr_fire && wr_idx == 3'h4) begin
			imask <= pwdata[2:0];
		end
	end

	// Level interrupt output
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ist & imask);
		end
	end

	////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset);

	lvd_follow_a: assert property (
		processor_flags[`SCF_LVD_BIT]
		== $past(lvd_s2 & low_voltage_reset_enable
		& ~supply_filter_select))
		else $error("low-voltage flag wrong");

	lvd_gate_a: assert property (
		(~low_voltage_reset_enable | supply_filter_select)
		|=> ~processor_flags[`SCF_LVD_BIT])
		else $error("low-voltage flag not gated");

	wdt_set_a: assert property (
		watchdog_timeout
		|=> processor_flags[`SCF_WDT_BIT])
		else $error("watchdog flag not set");

	wdt_clear_a: assert property (
		(watchdog_kick_instruction | sleep_exec
		| low_voltage_reset) && !watchdog_timeout
		|=> !processor_flags[`SCF_WDT_BIT])
		else $error("watchdog flag not cleared");

	pd_set_a: assert property (
		sleep_exec
		|=> processor_flags[`SCF_PD_BIT])
		else $error("power down flag not set");

	pd_clear_a: assert property (
		(watchdog_kick_instruction | low_voltage_reset)
		&& !sleep_exec
		|=> !processor_flags[`SCF_PD_BIT])
		else $error("power down flag not cleared");

	zero_flag_a: assert property (
		alu_result.upd
		|=> processor_flags[`SCF_ZERO_BIT]
		== $past(alu_result.zero))
		else $error("zero flag wrong");

	nib_flag_a: assert property (
		alu_result.upd
		|=> processor_flags[`SCF_NIB_BIT]
		== $past(alu_result.nib_carry))
		else $error("nibble carry wrong");

	bit_set_a: assert property (
		wr_fire && wr_idx == 3'h1 && pwdata[0]
		&& !alu_result.upd
		|=> processor_flags[0]
		&& processor_flags[6:5] == $past(processor_flags[6:5] | pwdata[6:5]))
		else $error("bit set disturbed others");

	msb_flag_a: assert property (
		alu_result.upd
		|=> processor_flags[`SCF_MSB_BIT]
		== $past(alu_result.msb_carry))
		else $error("msb carry wrong");

	alu_wins_a: assert property (
		wr_fire && wr_idx == 3'h0 && alu_result.upd
		|=> processor_flags[2:0] == $past({alu_result.zero,
		alu_result.nib_carry, alu_result.msb_carry}))
		else $error("write beat ALU flags");

	bank_sel_a: assert property (
		wr_fire && wr_idx == 3'h0
		|=> memory_bank_select == $past(pwdata[5]))
		else $error("bank select not written");

	spare_bit_a: assert property (
		wr_fire && wr_idx == 3'h0
		|=> processor_flags[6] == $past(pwdata[6]))
		else $error("spare bit not stored");

	ro_ignore_a: assert property (
		wr_fire && wr_idx == 3'h0 && !sleep_exec
		&& !watchdog_timeout && !watchdog_kick_instruction
		&& !low_voltage_reset
		|=> processor_flags[4:3] == $past(processor_flags[4:3]))
		else $error("read-only bits written");

	apb_ready_a: assert property (
		setup_ph |=> pready ##1 (!pready || setup_ph))
		else $error("pready timing wrong");

	irq_level_a: assert property (
		|(ist & imask) |=> irq)
		else $error("interrupt not raised");

	bit_clear_a: assert property (
		wr_fire && wr_idx == 3'h2 && pwdata[0]
		&& !alu_result.upd
		|=> !processor_flags[0]
		&& processor_flags[6:5] == $past(processor_flags[6:5] & ~pwdata[6:5]))
		else $error("bit clear disturbed others");

	window_ro_a: assert property (
		wr_fire && (wr_idx == 3'h1 || wr_idx == 3'h2)
		&& !sleep_exec && !watchdog_timeout
		&& !watchdog_kick_instruction && !low_voltage_reset
		|=> processor_flags[4:3] == $past(processor_flags[4:3]))
		else $error("window wrote read-only bits");

	bank_set_a: assert property (
		wr_fire && wr_idx == 3'h1 && pwdata[5]
		|=> memory_bank_select)
		else $error("bank select not set");

	lvd_event_a: assert property (
		next_lvd && !processor_flags[`SCF_LVD_BIT]
		|=> ist[`SCF_EV_LVD])
		else $error("supply event not latched");

	status_sticky_a: assert property (
		!(wr_fire && wr_idx == 3'h3)
		|=> (ist & $past(ist)) == $past(ist))
		else $error("status bit lost");

	unmapped_err_a: assert property (
		setup_ph && rd_idx == 3'h7
		|=> pslverr)
		else $error("unmapped access not refused");

	flags_read_a: assert property (
		setup_ph && !pwrite && rd_idx == 3'h0
		|=> prdata == {24'h00_0000, $past(processor_flags)})
		else $error("flags read data wrong");

endmodule

// *** dv/scf_tb.sv ***
/*
 Self-checking bench of the processor flags block: APB
 register access, core events, ALU flags, supply detect
 and the event interrupt.
 Assumes scf_defs.svh on the include path.
*/
`timescale 1ns/1ps
`include "scf_defs.svh"
module tb;
	import scf_pkg::*;
	logic            core_clk;
	logic            reset;
	logic            psel;
	logic            penable;
	logic            pwrite;
	logic [7:0]      paddr;
	logic [31:0]     pwdata;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	scf_alu_s        alu_result;
	logic            sleep_exec;
	logic            watchdog_kick_instruction;
	logic            watchdog_timeout;
	logic            low_voltage_reset;
	logic            supply_below_pin;
	logic            low_voltage_reset_enable;
	logic            supply_filter_select;
	logic [7:0]      processor_flags;
	logic            memory_bank_select;
	logic            irq;
	logic [31:0]     r;
	logic [31:0]     x;
	logic            e;
	int              m;
	int              error_cnt;
	int              n_checks;

	scf_status_flags uut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .alu_result, .sleep_exec, .watchdog_kick_instruction, .watchdog_timeout, .low_voltage_reset,
		.supply_below_pin, .low_voltage_reset_enable, .supply_filter_select, .processor_flags,
		.memory_bank_select, .irq);

	////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		core_clk = 0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		complete_run;
	end

	////////////////////////////////////////////////////////////
	// Compare and report
	task chk(input logic [31:0] s, input logic [31:0] xp);
		n_checks++;
		if (s !== xp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, s, xp);
		end
	endtask

	task complete_run;
		if (error_cnt == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One APB transfer, result left in r and e
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1;
		penable <= 0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1;
		// Answer and read data taken at the edge that sees pready
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		r = prdata;
		e = pslverr;
		psel    <= 0;
		penable <= 0;
	endtask

	// One core event pulse, model update and check
	task ev(input int k);
		@(posedge core_clk);
		case (k)
			0: watchdog_timeout <= 1;
			1: sleep_exec <= 1;
			2: watchdog_kick_instruction <= 1;
			default: low_voltage_reset <= 1;
		endcase
		@(posedge core_clk);
		{watchdog_timeout, sleep_exec, watchdog_kick_instruction, low_voltage_reset} <= 4'h0;
		@(negedge core_clk);
		case (k)
			0: m = m | 16;
			1: m = (m | 8) & ~16;
			default: m = m & ~24;
		endcase
		chk(processor_flags & 8'h18, m & 8'h18);
	endtask

	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{sleep_exec, watchdog_kick_instruction, watchdog_timeout, low_voltage_reset} = 4'h0;
		{supply_below_pin, low_voltage_reset_enable, supply_filter_select} = 3'h0;
		alu_result = '0;
		void'($urandom(35));
		repeat (12) @(posedge core_clk);
		reset <= 0;
		m = 0;
		apb(0, `SCF_FLAGS_OFS, 0);
		chk(r, 0);
		apb(1, `SCF_FLAGS_OFS, 32'hFF);
		apb(0, `SCF_FLAGS_OFS, 0);
		chk(r, 32'h67);
		chk(memory_bank_select, 1);
		apb(1, `SCF_CLR_OFS, 32'h01);
		apb(0, `SCF_FLAGS_OFS, 0);
		chk(r, 32'h66);
		apb(1, `SCF_SET_OFS, 32'h01);
		apb(1, `SCF_CLR_OFS, 32'h20);
		apb(0, `SCF_FLAGS_OFS, 0);
		chk(r, 32'h47);
		chk(memory_bank_select, 0);
		m = 32'h47;
		// Event order exercises set and every clear path except the low_voltage_reset clear of the watchdog flag
		ev(0);
		ev(1);
		ev(0);
		ev(2);
		ev(1);
		ev(3);
		apb(0, `SCF_ISTAT_OFS, 0);
		chk(r, 3);
		chk(irq, 0);
		apb(1, `SCF_IMASK_OFS, 2);
		repeat (2) @(negedge core_clk);
		chk(irq, 1);
		apb(1, `SCF_ISTAT_OFS, 2);
		repeat (2) @(negedge core_clk);
		chk(irq, 0);
		apb(0, `SCF_ISTAT_OFS, 0);
		chk(r, 1);
		// Random ALU flag results
		repeat (8) begin
			x = $urandom;
			@(posedge core_clk);
			alu_result <= {1'b1, x[2:0]};
			@(posedge core_clk);
			alu_result <= '0;
			@(negedge core_clk);
			chk(processor_flags[2:0], x[2:0]);
		end
		// ALU update lands on the same edge as a whole write
		fork
			apb(1, `SCF_FLAGS_OFS, 32'h47);
			begin
				repeat (2) @(posedge core_clk);
				alu_result <= 4'h8;
				@(posedge core_clk);
				alu_result <= '0;
			end
		join
		@(negedge core_clk);
		chk(processor_flags & 8'h47, 8'h40);
		// Supply detect under every qualifier combination
		for (int k = 0; k < 8; k++) begin
			@(posedge core_clk);
			{supply_below_pin, low_voltage_reset_enable, supply_filter_select} <= k[2:0];
			repeat (5) @(negedge core_clk);
			chk(processor_flags[7], k[2] & k[1] & !k[0]);
		end
		// Unmapped address is refused
		apb(1, 8'h14, 32'hFF);
		chk(e, 1);
		apb(0, 8'h14, 0);
		chk(e, 1);
		chk(r, 0);
		apb(0, `SCF_FLAGS_OFS, 0);
		chk(r & 32'h60, 32'h40);
		complete_run;
	end
endmodule
